//--- mts_params.svh
// Constants for the measurement trigger sequencer
`ifndef MTS_PARAMS_SVH
`define MTS_PARAMS_SVH
`define MTS_CLK_HZ 20000000
`define MTS_SAMPLES_MAX 50000
`define MTS_SAMPLES_DEF 16'h0001
`define MTS_DELAY_MAX_S 3600
`define MTS_DELAY_DEF 12'h000
`define MTS_DONE_PULSE_CYC 20
`define MTS_HOLD_RUN 3
`define MTS_BAND_DEF 2'h1
`define MTS_SRC_AUTO 2'h0
`define MTS_SRC_SINGLE 2'h1
`define MTS_SRC_EXT 2'h2
`endif

//--- mts_pkg.sv
// Types shared by the measurement trigger sequencer
`default_nettype none
package mts_pkg;
	typedef enum logic [1:0] {
		MTS_SRC_AUTO_E = 2'h0,
		MTS_SRC_SINGLE_E = 2'h1,
		MTS_SRC_EXT_E = 2'h2
	} mts_src_t;
	typedef enum logic [1:0] {
		MTS_BAND_0P01 = 2'h0,
		MTS_BAND_0P1 = 2'h1,
		MTS_BAND_1 = 2'h2,
		MTS_BAND_10 = 2'h3
	} mts_band_t;
	typedef struct packed {
		mts_src_t src;
		logic [15:0] samples;
		logic delay_manual;
		logic [11:0] delay_s;
		logic trig_out_en;
	} mts_cfg_t;
	typedef struct packed {
		logic valid;
		logic signed [31:0] value;
	} mts_reading_t;
endpackage : mts_pkg
`default_nettype wire

//--- mts_hold.sv
// Reading hold filter: stability detection and display latch
`include "mts_params.svh"
`default_nettype none
module mts_hold (
	input wire logic clk_in,
	input wire logic resetn_in,
	input wire logic enable_in,
	input wire mts_pkg::mts_band_t band_in,
	input wire mts_pkg::mts_reading_t reading_in,
	output logic signed [31:0] display_out,
	output logic display_valid_out
);
	logic signed [31:0] ref_val;
	logic [1:0] run;
	logic signed [31:0] next_ref_val;
	logic [1:0] next_run;
	logic signed [31:0] next_display;
	logic next_display_valid;

	function automatic logic in_band(input logic signed [31:0] a,
			input logic signed [31:0] b, input mts_pkg::mts_band_t band);
		logic [63:0] diff;
		logic [63:0] mag;
		logic [63:0] lim;
		diff = (a > b) ? 64'(a - b) : 64'(b - a);
		mag = (b < 0) ? 64'(-b) : 64'(b);
		case (band)
			mts_pkg::MTS_BAND_0P01: lim = mag;
			mts_pkg::MTS_BAND_0P1: lim = mag * 64'h0a;
			mts_pkg::MTS_BAND_1: lim = mag * 64'h64;
			default: lim = mag * 64'h3e8;
		endcase
		// diff <= mag*band/100% expressed against a scale of 10000
		in_band = (diff * 64'h2710) <= lim;
	endfunction : in_band

	always_comb begin
		next_ref_val = ref_val;
		next_run = run;
		next_display = display_out;
		next_display_valid = display_valid_out;
		if (!enable_in) begin
			next_run = 2'h0;
			if (reading_in.valid) begin
				next_display = reading_in.value; // Bypass while hold is off or remote
				next_display_valid = 1'b1;
			end
		end else if (reading_in.valid) begin
			if (run == 2'h0 || !in_band(reading_in.value, ref_val, band_in)) begin
				next_ref_val = reading_in.value;
				next_run = 2'h1;
			end else if (run == 2'(`MTS_HOLD_RUN - 1)) begin
				next_run = 2'h0; // Three in band: stable
				if (!display_valid_out || !in_band(reading_in.value, display_out, band_in)) begin
					next_display = reading_in.value; // Keep display if close
					next_display_valid = 1'b1;
				end
			end else begin
				next_run = run + 2'h1;
			end
		end
	end

	always_ff @(posedge clk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			ref_val <= 32'sh0;
			run <= 2'h0;
			display_out <= 32'sh0;
			display_valid_out <= 1'b0;
		end else begin
			ref_val <= next_ref_val;
			run <= next_run;
			display_out <= next_display;
			display_valid_out <= next_display_valid;
		end
	end
endmodule : mts_hold
`default_nettype wire

//--- mts_sequencer.sv
// Measurement trigger sequencer top level
// Functional notes
// - Automatic trigger source after power-up
// - Automatic source runs readings back to back
// - Single key starts one sample-count cycle
// - External falling pulse starts one cycle
// - Source returns to automatic on reset
// - Sampling indicator high during each measurement
// - Single key in remote returns local
// - Reading hold ignored in remote operation
// - Stable after three consecutive in-band readings
// - Band 0.01/0.1/1/10 percent, default 0.1
// - Keep display if stable reading is close
// - Sample count 1 to 50000, default 1
// - Sample count forced to one on reset
// - Delay after trigger and before each reading
// - Manual delay 1 to 3600 s, default 0
// - Reset selects automatic delay mode
// - Manual delay same for all functions
// - Low completion pulse after each measurement
// - Switch unit handshakes via trigger and completion
// - Completion pulses only while output enabled
`include "mts_params.svh"
`default_nettype none
module mts_sequencer #(
	parameter int CLK_HZ = `MTS_CLK_HZ,
	parameter int DONE_PULSE_CYC = `MTS_DONE_PULSE_CYC,
	parameter int AUTO_DELAY_CYC = 1
) (
	input wire logic clk_in,
	input wire logic resetn_in,
	input wire logic remote_reset_in,
	input wire mts_pkg::mts_cfg_t cfg_in,
	input wire logic cfg_write_in,
	input wire logic hold_on_in,
	input wire mts_pkg::mts_band_t band_in,
	input wire logic band_write_in,
	input wire logic single_key_in,
	input wire logic remote_in,
	input wire logic ext_trig_n_in,
	output logic conv_start_out,
	input wire logic conv_done_in,
	input wire logic signed [31:0] conv_value_in,
	output mts_pkg::mts_cfg_t cfg_out,
	output logic go_local_out,
	output logic sampling_out,
	output logic busy_out,
	output logic conversion_done_pulse_out,
	output logic signed [31:0] display_out,
	output logic display_valid_out
);
	// ----------------------------------------------------------------
	// Parameter checks
	// ----------------------------------------------------------------
	// Pulse counter is 16 bits wide, so longer pulses cannot be served
	if (CLK_HZ < 1 || DONE_PULSE_CYC < 1 || DONE_PULSE_CYC > 65535
			|| AUTO_DELAY_CYC < 1) begin : g_bad_param
		$error("mts_sequencer: bad parameter");
	end

	localparam int SEC_CYC = CLK_HZ;

	typedef enum logic [3:0] {
		ST_IDLE = 4'h1,
		ST_DELAY = 4'h2,
		ST_START = 4'h4,
		ST_MEAS = 4'h8
	} mts_state_t;

	// ----------------------------------------------------------------
	// Configuration
	// ----------------------------------------------------------------
	mts_pkg::mts_cfg_t cfg;
	mts_pkg::mts_cfg_t next_cfg;
	mts_pkg::mts_band_t band;
	mts_pkg::mts_band_t next_band;

	always_comb begin
		next_cfg = cfg;
		next_band = band;
		// Remote reset outranks a write in the same cycle
		if (remote_reset_in) begin
			next_cfg.src = mts_pkg::mts_src_t'(`MTS_SRC_AUTO);
			next_cfg.samples = `MTS_SAMPLES_DEF;
			next_cfg.delay_manual = 1'b0;
			next_cfg.delay_s = `MTS_DELAY_DEF;
		end else if (cfg_write_in) begin
			if (cfg_in.src != mts_pkg::mts_src_t'(2'h3))
				next_cfg.src = cfg_in.src;
			// Out-of-range values are refused; old value kept
			if (cfg_in.samples >= 16'h0001 && cfg_in.samples <= 16'(`MTS_SAMPLES_MAX))
				next_cfg.samples = cfg_in.samples;
			if (!cfg_in.delay_manual ||
					(cfg_in.delay_s >= 12'h001 && cfg_in.delay_s <= 12'(`MTS_DELAY_MAX_S))) begin
				next_cfg.delay_manual = cfg_in.delay_manual;
				next_cfg.delay_s = cfg_in.delay_s;
			end
			// Output enable and band survive a remote reset
			next_cfg.trig_out_en = cfg_in.trig_out_en;
		end
		if (band_write_in)
			next_band = band_in;
	end

	always_ff @(posedge clk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			cfg.src <= mts_pkg::mts_src_t'(`MTS_SRC_AUTO);
			cfg.samples <= `MTS_SAMPLES_DEF;
			cfg.delay_manual <= 1'b0;
			cfg.delay_s <= `MTS_DELAY_DEF;
			cfg.trig_out_en <= 1'b0;
			band <= mts_pkg::mts_band_t'(`MTS_BAND_DEF);
		end else begin
			cfg <= next_cfg;
			band <= next_band;
		end
	end

	assign cfg_out = cfg;

	// ----------------------------------------------------------------
	// Trigger inputs
	// ----------------------------------------------------------------
	logic ext_s1;
	logic ext_s2;
	logic ext_prev;
	logic key_prev;
	logic ext_fall;
	logic key_press;

	// Two flops ahead of the edge detector keep a late edge from splitting
	// Key is taken as already debounced
	always_ff @(posedge clk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			ext_s1 <= 1'b1;
			ext_s2 <= 1'b1;
			ext_prev <= 1'b1;
			key_prev <= 1'b0;
		end else begin
			ext_s1 <= ext_trig_n_in;
			ext_s2 <= ext_s1;
			ext_prev <= ext_s2;
			key_prev <= single_key_in;
		end
	end

	assign ext_fall = ext_prev && !ext_s2;
	assign key_press = single_key_in && !key_prev;
	// A key press in remote only hands control back; it fires nothing
	assign go_local_out = key_press && remote_in;

	// ----------------------------------------------------------------
	// Sequencer
	// ----------------------------------------------------------------
	mts_state_t state;
	mts_state_t next_state;
	logic [15:0] left;
	logic [15:0] next_left;
	logic [31:0] sec_cnt;
	logic [31:0] next_sec_cnt;
	logic [11:0] dly_s;
	logic [11:0] next_dly_s;
	logic trig;
	logic dly_done;
	logic [11:0] reload_dly_s;
	logic [31:0] reload_sec_cnt;

	// Auto source re-arms on every idle cycle, so readings run back to back
	always_comb begin
		case (cfg.src)
			mts_pkg::MTS_SRC_AUTO_E: trig = 1'b1;
			mts_pkg::MTS_SRC_SINGLE_E: trig = key_press && !remote_in;
			mts_pkg::MTS_SRC_EXT_E: trig = ext_fall;
			default: trig = 1'b0;
		endcase
	end

	// Manual delay counts whole seconds, same for any function
	assign dly_done = cfg.delay_manual ? (dly_s == 12'h000 && sec_cnt == 32'h0)
		: (sec_cnt == 32'h0);
	// First and later readings share one reload so their delays match
	assign reload_dly_s = cfg.delay_manual ? cfg.delay_s - 12'h001 : 12'h000;
	assign reload_sec_cnt = cfg.delay_manual ? 32'(SEC_CYC - 1) : 32'(AUTO_DELAY_CYC - 1);

	// Delay counts cycles within a second, then whole seconds

	always_comb begin
		next_state = state;
		next_left = left;
		next_sec_cnt = sec_cnt;
		next_dly_s = dly_s;
		case (state)
			ST_IDLE: begin
				if (trig) begin // Edges while busy are dropped
					next_left = cfg.samples;
					next_state = ST_DELAY;
					next_dly_s = reload_dly_s;
					next_sec_cnt = reload_sec_cnt;
				end
			end
			ST_DELAY: begin
				if (dly_done) begin
					next_state = ST_START;
				end else if (sec_cnt == 32'h0) begin
					next_dly_s = dly_s - 12'h001;
					next_sec_cnt = 32'(SEC_CYC - 1);
				end else begin
					next_sec_cnt = sec_cnt - 32'h1;
				end
			end
			ST_START: next_state = ST_MEAS;
			ST_MEAS: begin
				if (conv_done_in) begin
					next_left = left - 16'h0001;
					if (left == 16'h0001) begin
						next_state = ST_IDLE;
					end else begin
						next_state = ST_DELAY; // Delay again before each reading
						next_dly_s = reload_dly_s;
						next_sec_cnt = reload_sec_cnt;
					end
				end
			end
			default: next_state = ST_IDLE;
		endcase
	end

	always_ff @(posedge clk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			state <= ST_IDLE;
			left <= 16'h0000;
			sec_cnt <= 32'h0;
			dly_s <= 12'h000;
		end else begin
			state <= next_state;
			left <= next_left;
			sec_cnt <= next_sec_cnt;
			dly_s <= next_dly_s;
		end
	end

	// ----------------------------------------------------------------
	// Status outputs
	// ----------------------------------------------------------------
	// Decoded from the state, so start carries no extra latency

	assign conv_start_out = (state == ST_START);
	assign sampling_out = (state == ST_START) || (state == ST_MEAS);
	assign busy_out = (state != ST_IDLE);

	// ----------------------------------------------------------------
	// Completion pulse
	// ----------------------------------------------------------------
	logic [15:0] pulse_cnt;
	logic [15:0] next_pulse_cnt;
	logic done_n;
	logic next_done_n;

	always_comb begin
		next_pulse_cnt = pulse_cnt;
		// A new completion restarts the width count; the load wins
		if (state == ST_MEAS && conv_done_in && cfg.trig_out_en)
			next_pulse_cnt = 16'(DONE_PULSE_CYC);
		else if (pulse_cnt != 16'h0000)
			next_pulse_cnt = pulse_cnt - 16'h0001;
		next_done_n = (next_pulse_cnt == 16'h0000);
	end

	always_ff @(posedge clk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			pulse_cnt <= 16'h0000;
			done_n <= 1'b1;
		end else begin
			pulse_cnt <= next_pulse_cnt;
			done_n <= next_done_n;
		end
	end

	assign conversion_done_pulse_out = done_n;

	// ----------------------------------------------------------------
	// Reading hold
	// ----------------------------------------------------------------
	// Only readings that end a measurement reach the filter
	mts_pkg::mts_reading_t reading;

	always_comb begin
		reading.valid = (state == ST_MEAS) && conv_done_in;
		reading.value = conv_value_in;
	end

	mts_hold u_hold (
		.clk_in(clk_in),
		.resetn_in(resetn_in),
		.enable_in(hold_on_in && !remote_in),
		.band_in(band),
		.reading_in(reading),
		.display_out(display_out),
		.display_valid_out(display_valid_out)
	);
endmodule : mts_sequencer
`default_nettype wire

//--- mts_sequencer_assertions.sv
// Port-level checks of the trigger sequencer
`default_nettype none
module mts_seq_chk #(
	parameter int DONE_PULSE_CYC = 20
) (
	input wire logic clk_in,
	input wire logic resetn_in,
	input wire logic remote_reset_in,
	input wire logic cfg_write_in,
	input wire logic single_key_in,
	input wire logic remote_in,
	input wire logic conv_done_in,
	input wire logic conv_start_out,
	input wire mts_pkg::mts_cfg_t cfg_out,
	input wire logic go_local_out,
	input wire logic sampling_out,
	input wire logic busy_out,
	input wire logic conversion_done_pulse_out
);
	timeunit 1ns;
	timeprecision 1ns;
	int low_cnt;
	always_ff @(posedge clk_in or negedge resetn_in) begin
		if (!resetn_in) low_cnt <= 0;
		else if (conversion_done_pulse_out) low_cnt <= 0;
		else low_cnt <= low_cnt + 1;
	end
	default clocking @(posedge clk_in);
	endclocking
	default disable iff (!resetn_in);
	start_in_samp_a: assert property (conv_start_out |-> sampling_out && busy_out)
		else $error("start outside sampling");
	start_single_a: assert property (conv_start_out |=> !conv_start_out && sampling_out)
		else $error("start not one cycle");
	samp_until_done_a: assert property (
		sampling_out && !conv_start_out && !conv_done_in |=> sampling_out)
		else $error("sampling dropped early");
	done_pulse_a: assert property (sampling_out && !conv_start_out && conv_done_in
		&& cfg_out.trig_out_en |=> !conversion_done_pulse_out)
		else $error("no completion pulse");
	done_gate_a: assert property (
		$fell(conversion_done_pulse_out) |-> $past(cfg_out.trig_out_en))
		else $error("pulse while output off");
	pulse_width_a: assert property (
		$rose(conversion_done_pulse_out) |-> low_cnt == DONE_PULSE_CYC)
		else $error("pulse width wrong");
	key_local_a: assert property ($rose(single_key_in) && remote_in |-> ##[0:3] go_local_out)
		else $error("no return to local");
	remote_rst_a: assert property (remote_reset_in && !cfg_write_in
		|=> cfg_out.samples == 16'h0001 && cfg_out.delay_s == 12'h000
		&& cfg_out.src == mts_pkg::MTS_SRC_AUTO_E && !cfg_out.delay_manual)
		else $error("remote reset defaults wrong");
	cover property (conv_start_out);
	cover property (go_local_out);
	cover property ($fell(conversion_done_pulse_out));
endmodule : mts_seq_chk
bind mts_sequencer mts_seq_chk #(.DONE_PULSE_CYC(DONE_PULSE_CYC)) u_mts_seq_chk (.clk_in,
	.resetn_in, .remote_reset_in, .cfg_write_in, .single_key_in, .remote_in, .conv_done_in,
	.conv_start_out, .cfg_out, .go_local_out, .sampling_out, .busy_out,
	.conversion_done_pulse_out);
`default_nettype wire

//--- mts_conv_model.sv
// Converter model answering each start after a set latency
`default_nettype none
module mts_conv_model (
	input wire logic clk_in,
	input wire logic resetn_in,
	input wire logic start_in,
	input wire logic [2:0] lat_in,
	input wire logic signed [31:0] val_in,
	output logic done_out,
	output logic signed [31:0] value_out
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [3:0] cnt;
	// Value is only valid with done; otherwise show the inverse
	assign value_out = done_out ? val_in : ~val_in;
	always @(posedge clk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			cnt <= 4'h0;
			done_out <= 1'b0;
		end else begin
			done_out <= (cnt == 4'h1);
			if (start_in) cnt <= 4'h4 + lat_in;
			else if (cnt != 4'h0) cnt <= cnt - 4'h1;
		end
	end
endmodule : mts_conv_model
`default_nettype wire

//--- tb.sv
// Self-checking bench of the trigger sequencer
`default_nettype none
`define CHK(nm, e, g) begin checked++; if ((g) !== (e)) begin n_mismatch++; \
	$display("mismatch %s exp %0h got %0h", nm, e, g); end end
module tb;
	timeunit 1ns;
	timeprecision 1ns;
	logic clk_in = 0, resetn_in = 0, rr = 0, cw = 0, hold = 0, bw = 0, key = 0, rem = 0, ext_n = 1;
	mts_pkg::mts_cfg_t cfg = '0, cfg_o;
	mts_pkg::mts_band_t band = mts_pkg::MTS_BAND_10;
	logic st, dn, gl, samp, busy, cdp, dv;
	logic signed [31:0] cv, disp, val = 0, prev;
	logic [2:0] lat = 3'h7;
	int seed = 77192, n_mismatch = 0, checked = 0, n_st = 0, n_dn = 0, n_gl = 0;
	time t0, t_st, t_prev;
	mts_sequencer #(.CLK_HZ(10), .DONE_PULSE_CYC(4)) u_mts_sequencer (.clk_in, .resetn_in,
		.remote_reset_in(rr), .cfg_in(cfg), .cfg_write_in(cw), .hold_on_in(hold),
		.band_in(band), .band_write_in(bw), .single_key_in(key), .remote_in(rem),
		.ext_trig_n_in(ext_n), .conv_start_out(st), .conv_done_in(dn), .conv_value_in(cv),
		.cfg_out(cfg_o), .go_local_out(gl), .sampling_out(samp), .busy_out(busy),
		.conversion_done_pulse_out(cdp), .display_out(disp), .display_valid_out(dv));
	mts_conv_model u_mts_conv_model (.clk_in, .resetn_in, .start_in(st), .lat_in(lat),
		.val_in(val), .done_out(dn), .value_out(cv));
	initial forever #25 clk_in = ~clk_in;
	always @(posedge st) begin
		n_st++;
		t_prev = t_st;
		t_st = $time;
	end
	always @(negedge cdp) n_dn++;
	always @(posedge gl) n_gl++;
	// ----------------------------------------
	// Helpers
	// ----------------------------------------
	task automatic cyc(input int n);
		repeat (n) @(posedge clk_in);
		#2;
	endtask : cyc
	task automatic wcfg(input mts_pkg::mts_src_t s, input int n, input logic m, input int d,
			input logic e);
		cfg = '{s, n[15:0], m, d[11:0], e};
		cw = 1;
		cyc(1);
		cw = 0;
		cyc(1);
	endtask : wcfg
	function automatic logic signed [31:0] hold_exp(input longint o, nw, k);
		longint a;
		a = (nw > o) ? nw - o : o - nw;
		return 32'((a * 10000 <= ((o < 0) ? -o : o) * k) ? o : nw);
	endfunction : hold_exp
	task automatic results;
		if (n_mismatch == 0 && checked > 0) $display("bench passed");
		else $display("bench failed");
		$finish;
	endtask : results
	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	initial begin
		#200000;
		n_mismatch++;
		results;
	end
	initial begin
		cyc(2);
		resetn_in = 1;
		cyc(1);
		`CHK("src", mts_pkg::MTS_SRC_AUTO_E, cfg_o.src)
		`CHK("samples", 16'h0001, cfg_o.samples)
		`CHK("delay", 13'h0000, {cfg_o.delay_manual, cfg_o.delay_s})
		repeat (4) begin
			val = $random(seed);
			lat = 3'($random(seed));
			cyc(60);
			`CHK("display", val, disp)
		end
		`CHK("no pulses", 0, n_dn)
		bw = 1;
		cyc(1);
		bw = 0;
		hold = 1;
		prev = val;
		val = 1000;
		cyc(100);
		`CHK("hold new", hold_exp(prev, 1000, 1000), disp)
		`CHK("valid", 1'b1, dv)
		val = 1050;
		cyc(100);
		`CHK("hold keep", hold_exp(1000, 1050, 1000), disp)
		val = 5000;
		cyc(100);
		`CHK("hold move", hold_exp(1000, 5000, 1000), disp)
		rem = 1;
		val = 5010;
		cyc(60);
		`CHK("remote", 32'sd5010, disp)
		rem = 0;
		band = mts_pkg::MTS_BAND_0P01;
		bw = 1;
		cyc(1);
		bw = 0;
		val = 5011;
		cyc(100);
		`CHK("hold fine", hold_exp(5010, 5011, 1), disp)
		hold = 0;
		lat = 3'h7;
		wcfg(mts_pkg::MTS_SRC_EXT_E, 3, 0, 0, 1);
		cyc(40);
		n_st = 0;
		n_dn = 0;
		cyc(40);
		`CHK("ext idle", 0, n_st)
		ext_n = 0;
		cyc(3);
		ext_n = 1;
		cyc(10);
		ext_n = 0;
		cyc(3);
		ext_n = 1;
		cyc(150);
		`CHK("ext starts", 3, n_st)
		`CHK("ext pulses", 3, n_dn)
		wcfg(mts_pkg::MTS_SRC_SINGLE_E, 2, 1, 2, 1);
		n_st = 0;
		t0 = $time;
		key = 1;
		cyc(3);
		key = 0;
		cyc(120);
		`CHK("key starts", 2, n_st)
		`CHK("first delay", 1'b1, t_prev - t0 >= 1000)
		`CHK("next delay", 1'b1, t_st - t_prev >= 1000)
		rem = 1;
		key = 1;
		cyc(3);
		key = 0;
		cyc(60);
		`CHK("go local", 1, n_gl)
		`CHK("remote key", 2, n_st)
		wcfg(mts_pkg::MTS_SRC_SINGLE_E, 50000, 0, 0, 1);
		wcfg(mts_pkg::MTS_SRC_SINGLE_E, 50001, 1, 5, 1);
		`CHK("max samples", 16'hc350, cfg_o.samples)
		rr = 1;
		cyc(1);
		rr = 0;
		cyc(1);
		`CHK("rst src", mts_pkg::MTS_SRC_AUTO_E, cfg_o.src)
		`CHK("rst cfg", 29'h2000, {cfg_o.samples, cfg_o.delay_manual, cfg_o.delay_s})
		wcfg(mts_pkg::MTS_SRC_AUTO_E, 1, 0, 0, 0);
		n_dn = 0;
		cyc(60);
		`CHK("off pulses", 0, n_dn)
		results;
	end
endmodule : tb
`default_nettype wire
